// ### src/ofc_defines.vh
// Notes on behaviour
// - Erase 1 kB units to all ones.
// - Protection applies per 2 kB unit pair.
// - Refuse program or erase of read-only units.
// - Refuse erase of execute-only units too.
// - Execute-only units allow fetches, block data reads.
// - Programming writes one word per operation.
// - Program stores old AND new data.
// - Software cycles-per-microsecond value times array pulses.
// - Invalid accesses raise the access-violation source.
// - Violations: protected writes, execute-only data reads, and out-of-range or unaligned addresses.
// - Completed erase or program raises done source.
// - Volatile protection first; committing is irreversible.
// - Erase of bad address or protected unit fails.
// - Per-source mask gates the interrupt line.
// - Raw and masked status both readable.
// - Two status bits: done and violation.
// - Software clears sources by writing a mask.
`ifndef OFC_DEFINES_VH
`define OFC_DEFINES_VH
`define OFC_REG_ADDR 8'h00
`define OFC_REG_DATA 8'h04
`define OFC_REG_CMD 8'h08
`define OFC_REG_USEC 8'h0C
`define OFC_REG_PROT 8'h10
`define OFC_REG_PERM 8'h14
`define OFC_REG_RIS 8'h18
`define OFC_REG_IMR 8'h1C
`define OFC_REG_MIS 8'h20
`define OFC_REG_ICR 8'h24
`define OFC_CMD_PROG_BIT 0
`define OFC_CMD_ERASE_BIT 1
`define OFC_CMD_COMMIT_BIT 2
`define OFC_ST_BUSY_BIT 0
`define OFC_ST_FAIL_BIT 1
`define OFC_IRQ_DONE_BIT 0
`define OFC_IRQ_VIOL_BIT 1
`define OFC_PROT_RW 2'h0
`define OFC_PROT_RO 2'h1
`define OFC_PROT_XO 2'h2
`define OFC_USEC_RST 8'h0A
`define OFC_PROG_TIME_US 16'h0014
`define OFC_ERASE_TIME_US 16'h0064
`define OFC_ERASE_UNIT_LSB 10
`define OFC_PROT_UNIT_LSB 11
`define OFC_ERASE_LAST 8'hFF
`define OFC_ONES 32'hFFFFFFFF
`define OFC_RESP_OKAY 2'h0
`define OFC_RESP_SLVERR 2'h2
`endif

// ### src/ofc_flash_array.v
`default_nettype none
// Word-wide storage array with an AND-program and an erase write mode.
module ofc_flash_array #(
    parameter WORDS = 2048,
    parameter AW = 11
) (
    input wire clk_i,
    input wire wr_en_i,
    input wire wr_erase_i,
    input wire [AW-1:0] wr_addr_i,
    input wire [31:0] wr_data_i,
    input wire rd_en_i,
    input wire [AW-1:0] rd_addr_i,
    output wire [31:0] rd_data_o
);
`include "ofc_defines.vh"
    reg [31:0] mem [0:WORDS-1];
    reg [31:0] rd_data_ff;

    always @(posedge clk_i) begin
        if (wr_en_i) begin
            if (wr_erase_i) begin
                mem[wr_addr_i] <= `OFC_ONES;
            end else begin
                mem[wr_addr_i] <= mem[wr_addr_i] & wr_data_i;
            end
        end
        rd_data_ff <= rd_en_i ? mem[rd_addr_i] : 32'h00000000;
    end

    assign rd_data_o = rd_data_ff;
endmodule // ofc_flash_array
`default_nettype wire

// ### src/ofc_us_timer.v
`default_nettype none
// Counts a number of microseconds using a cycles-per-microsecond value.
module ofc_us_timer (
    input wire clk_i,
    input wire rst_n_i,
    input wire start_i,
    input wire [7:0] cyc_per_us_i,
    input wire [15:0] us_i,
    output wire done_o
);
    reg run_ff;
    reg [7:0] cyc_ff;
    reg [15:0] us_ff;
    reg done_ff;
    wire [7:0] cyc_max = (cyc_per_us_i == 8'h00) ? 8'h01 : cyc_per_us_i;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_ff <= 1'b0;
            cyc_ff <= 8'h00;
            us_ff <= 16'h0000;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start_i) begin
                run_ff <= 1'b1;
                cyc_ff <= 8'h00;
                us_ff <= (us_i == 16'h0000) ? 16'h0001 : us_i;
            end else if (run_ff) begin
                if (cyc_ff + 8'h01 >= cyc_max) begin
                    cyc_ff <= 8'h00;
                    if (us_ff <= 16'h0001) begin
                        run_ff <= 1'b0;
                        done_ff <= 1'b1;
                    end else begin
                        us_ff <= us_ff - 16'h0001;
                    end
                end else begin
                    cyc_ff <= cyc_ff + 8'h01;
                end
            end
        end
    end

    assign done_o = done_ff;
endmodule // ofc_us_timer
`default_nettype wire

// ### src/ofc_top.v
// Chosen here: the AXI4-Lite register port and the address map.
`default_nettype none
// Flash controller: register slave, protection, erase/program sequencer, read gate.
module ofc_top #(
    parameter FLASH_WORDS = 2048,
    parameter AW = 11,
    parameter NUNITS = 4
) (
    input wire CLOCK_I,
    input wire RST_N_I,
    input wire POR_N_I,
    input wire [7:0] S_AXI_AWADDR_I,
    input wire S_AXI_AWVALID_I,
    output wire S_AXI_AWREADY_O,
    input wire [31:0] S_AXI_WDATA_I,
    input wire [3:0] S_AXI_WSTRB_I,
    input wire S_AXI_WVALID_I,
    output wire S_AXI_WREADY_O,
    output wire [1:0] S_AXI_BRESP_O,
    output wire S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    input wire [7:0] S_AXI_ARADDR_I,
    input wire S_AXI_ARVALID_I,
    output wire S_AXI_ARREADY_O,
    output wire [31:0] S_AXI_RDATA_O,
    output wire [1:0] S_AXI_RRESP_O,
    output wire S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I,
    input wire RD_REQ_I,
    input wire [31:0] RD_ADDR_I,
    input wire RD_FETCH_I,
    output wire RD_VALID_O,
    output wire [31:0] RD_DATA_O,
    output wire RD_ERR_O,
    output wire FLASH_IRQ_O
);
`include "ofc_defines.vh"
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_ERASE = 3'b010;
    localparam [2:0] S_WAIT = 3'b100;
    localparam [31:0] FLASH_BYTES = FLASH_WORDS * 4;

    reg aw_held_ff;
    reg [7:0] aw_addr_ff;
    reg w_held_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0] rresp_ff;
    reg [31:0] addr_ff;
    reg [31:0] data_ff;
    reg [7:0] usec_ff;
    reg [31:0] vprot_ff;
    reg [31:0] pprot_ff;
    reg [1:0] ris_ff;
    reg [1:0] imr_ff;
    reg fail_ff;
    reg [2:0] state_ff;
    reg [7:0] walk_ff;
    reg [AW-1:0] blk_base_ff;
    reg rd_valid_ff;
    reg rd_err_ff;
    reg [31:0] nxt_vprot;
    reg [31:0] eff_prot;
    reg [31:0] rd_mux;
    reg rd_hit;
    reg [1:0] nxt_ris;
    reg [2:0] nxt_state;
    reg nxt_fail;
    reg arr_wr_en;
    reg arr_erase;
    reg [AW-1:0] arr_addr;
    reg tmr_start;
    reg [15:0] tmr_us;
    reg set_done;
    reg set_viol;
    integer i;

    wire do_wr = aw_held_ff & w_held_ff & ~bvalid_ff;
    wire do_rd = S_AXI_ARVALID_I & ~rvalid_ff;
    wire tmr_done;
    wire [31:0] arr_rd_data;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] new_val;
        input [3:0] strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[8*b +: 8] = new_val[8*b +: 8];
                end
            end
        end
    endfunction

    function [1:0] tighter;
        input [1:0] a;
        input [1:0] b;
        begin
            if (a == `OFC_PROT_XO || b == `OFC_PROT_XO) begin
                tighter = `OFC_PROT_XO;
            end else if (a == `OFC_PROT_RO || b == `OFC_PROT_RO) begin
                tighter = `OFC_PROT_RO;
            end else begin
                tighter = `OFC_PROT_RW;
            end
        end
    endfunction

    function [1:0] prot_of;
        input [31:0] vec;
        input [31:0] byte_addr;
        reg [3:0] unit;
        begin
            unit = byte_addr[`OFC_PROT_UNIT_LSB +: 4];
            prot_of = vec[2*unit +: 2];
        end
    endfunction

    function in_flash;
        input [31:0] byte_addr;
        begin
            in_flash = (byte_addr < FLASH_BYTES) && (byte_addr[1:0] == 2'h0);
        end
    endfunction

    wire wr_sel_cmd = do_wr && aw_addr_ff == `OFC_REG_CMD && w_strb_ff[0];
    wire cmd_prog = wr_sel_cmd & w_data_ff[`OFC_CMD_PROG_BIT];
    wire cmd_erase = wr_sel_cmd & w_data_ff[`OFC_CMD_ERASE_BIT];
    wire cmd_commit = wr_sel_cmd & w_data_ff[`OFC_CMD_COMMIT_BIT];
    wire [1:0] cmd_prot = prot_of(eff_prot, addr_ff);
    wire rd_blocked = !in_flash(RD_ADDR_I) || (prot_of(eff_prot, RD_ADDR_I) == `OFC_PROT_XO && !RD_FETCH_I);

    always @* begin
        nxt_vprot = vprot_ff;
        for (i = 0; i < 16; i = i + 1) begin
            eff_prot[2*i +: 2] = tighter(vprot_ff[2*i +: 2], pprot_ff[2*i +: 2]);
            if (do_wr && aw_addr_ff == `OFC_REG_PROT && i < NUNITS) begin
                if (w_strb_ff[i/4] && w_data_ff[2*i +: 2] != 2'h3
                        && tighter(w_data_ff[2*i +: 2], vprot_ff[2*i +: 2]) == w_data_ff[2*i +: 2]) begin
                    nxt_vprot[2*i +: 2] = w_data_ff[2*i +: 2];
                end
            end
        end
    end

    always @* begin
        rd_hit = 1'b1;
        case (S_AXI_ARADDR_I)
            `OFC_REG_ADDR: rd_mux = addr_ff;
            `OFC_REG_DATA: rd_mux = data_ff;
            `OFC_REG_CMD: rd_mux = {30'h00000000, fail_ff, state_ff != S_IDLE};
            `OFC_REG_USEC: rd_mux = {24'h000000, usec_ff};
            `OFC_REG_PROT: rd_mux = vprot_ff;
            `OFC_REG_PERM: rd_mux = pprot_ff;
            `OFC_REG_RIS: rd_mux = {30'h00000000, ris_ff};
            `OFC_REG_IMR: rd_mux = {30'h00000000, imr_ff};
            `OFC_REG_MIS: rd_mux = {30'h00000000, ris_ff & imr_ff};
            `OFC_REG_ICR: rd_mux = 32'h00000000;
            default: begin
                rd_mux = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @* begin
        nxt_state = state_ff;
        nxt_fail = fail_ff;
        arr_wr_en = 1'b0;
        arr_erase = 1'b0;
        arr_addr = addr_ff[AW+1:2];
        tmr_start = 1'b0;
        tmr_us = `OFC_PROG_TIME_US;
        set_done = 1'b0;
        set_viol = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (cmd_prog) begin
                    nxt_fail = 1'b1;
                    if (!in_flash(addr_ff)) begin
                        set_viol = 1'b1;
                    end else if (cmd_prot != `OFC_PROT_RW) begin
                        set_viol = 1'b1;
                    end else begin
                        nxt_fail = 1'b0;
                        arr_wr_en = 1'b1;
                        tmr_start = 1'b1;
                        nxt_state = S_WAIT;
                    end
                end else if (cmd_erase) begin
                    nxt_fail = 1'b1;
                    if (!in_flash(addr_ff) || addr_ff[`OFC_ERASE_UNIT_LSB-1:0] != 10'h000) begin
                        set_viol = 1'b1;
                    end else if (cmd_prot != `OFC_PROT_RW) begin
                        set_viol = 1'b1;
                    end else begin
                        nxt_fail = 1'b0;
                        nxt_state = S_ERASE;
                    end
                end
            end
            S_ERASE: begin
                arr_wr_en = 1'b1;
                arr_erase = 1'b1;
                arr_addr = blk_base_ff | {{(AW-8){1'b0}}, walk_ff};
                if (walk_ff == `OFC_ERASE_LAST) begin
                    tmr_start = 1'b1;
                    tmr_us = `OFC_ERASE_TIME_US;
                    nxt_state = S_WAIT;
                end
            end
            S_WAIT: begin
                if (tmr_done) begin
                    set_done = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
        if (RD_REQ_I && rd_blocked) begin
            set_viol = 1'b1;
        end
    end

    always @* begin
        nxt_ris = ris_ff;
        if (do_wr && aw_addr_ff == `OFC_REG_ICR && w_strb_ff[0]) begin
            nxt_ris = ris_ff & ~w_data_ff[1:0];
        end
        if (set_done) begin
            nxt_ris[`OFC_IRQ_DONE_BIT] = 1'b1;
        end
        if (set_viol) begin
            nxt_ris[`OFC_IRQ_VIOL_BIT] = 1'b1;
        end
    end

    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `OFC_RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `OFC_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID_I && !aw_held_ff) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= S_AXI_AWADDR_I;
            end else if (do_wr) begin
                aw_held_ff <= 1'b0;
            end
            if (S_AXI_WVALID_I && !w_held_ff) begin
                w_held_ff <= 1'b1;
                w_data_ff <= S_AXI_WDATA_I;
                w_strb_ff <= S_AXI_WSTRB_I;
            end else if (do_wr) begin
                w_held_ff <= 1'b0;
            end
            if (do_wr) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= (aw_addr_ff[1:0] == 2'h0 && aw_addr_ff <= `OFC_REG_ICR) ? `OFC_RESP_OKAY : `OFC_RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                bvalid_ff <= 1'b0;
            end
            if (do_rd) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux;
                rresp_ff <= rd_hit ? `OFC_RESP_OKAY : `OFC_RESP_SLVERR;
            end else if (S_AXI_RREADY_I) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            addr_ff <= 32'h00000000;
            data_ff <= 32'h00000000;
            usec_ff <= `OFC_USEC_RST;
            vprot_ff <= 32'h00000000;
            ris_ff <= 2'h0;
            imr_ff <= 2'h0;
            fail_ff <= 1'b0;
            state_ff <= S_IDLE;
            walk_ff <= 8'h00;
            blk_base_ff <= {AW{1'b0}};
            rd_valid_ff <= 1'b0;
            rd_err_ff <= 1'b0;
        end else begin
            if (do_wr && aw_addr_ff == `OFC_REG_ADDR && state_ff == S_IDLE) begin
                addr_ff <= merge(addr_ff, w_data_ff, w_strb_ff);
            end
            if (do_wr && aw_addr_ff == `OFC_REG_DATA && state_ff == S_IDLE) begin
                data_ff <= merge(data_ff, w_data_ff, w_strb_ff);
            end
            if (do_wr && aw_addr_ff == `OFC_REG_USEC && w_strb_ff[0]) begin
                usec_ff <= w_data_ff[7:0];
            end
            if (do_wr && aw_addr_ff == `OFC_REG_IMR && w_strb_ff[0]) begin
                imr_ff <= w_data_ff[1:0];
            end
            vprot_ff <= nxt_vprot;
            ris_ff <= nxt_ris;
            fail_ff <= nxt_fail;
            state_ff <= nxt_state;
            if (state_ff == S_IDLE) begin
                walk_ff <= 8'h00;
                blk_base_ff <= {addr_ff[AW+1:`OFC_ERASE_UNIT_LSB], 8'h00};
            end else if (state_ff == S_ERASE) begin
                walk_ff <= walk_ff + 8'h01;
            end
            rd_valid_ff <= RD_REQ_I;
            rd_err_ff <= RD_REQ_I & rd_blocked;
        end
    end

    always @(posedge CLOCK_I or negedge POR_N_I) begin
        if (!POR_N_I) begin
            pprot_ff <= 32'h00000000;
        end else if (cmd_commit) begin
            pprot_ff <= eff_prot;
        end
    end

    ofc_flash_array #(
        .WORDS(FLASH_WORDS),
        .AW(AW)
    ) u_array (
        .clk_i(CLOCK_I),
        .wr_en_i(arr_wr_en),
        .wr_erase_i(arr_erase),
        .wr_addr_i(arr_addr),
        .wr_data_i(data_ff),
        .rd_en_i(RD_REQ_I & ~rd_blocked),
        .rd_addr_i(RD_ADDR_I[AW+1:2]),
        .rd_data_o(arr_rd_data)
    );

    ofc_us_timer u_timer (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .start_i(tmr_start),
        .cyc_per_us_i(usec_ff),
        .us_i(tmr_us),
        .done_o(tmr_done)
    );

    assign S_AXI_AWREADY_O = ~aw_held_ff;
    assign S_AXI_WREADY_O = ~w_held_ff;
    assign S_AXI_BVALID_O = bvalid_ff;
    assign S_AXI_BRESP_O = bresp_ff;
    assign S_AXI_ARREADY_O = ~rvalid_ff;
    assign S_AXI_RVALID_O = rvalid_ff;
    assign S_AXI_RDATA_O = rdata_ff;
    assign S_AXI_RRESP_O = rresp_ff;
    assign RD_VALID_O = rd_valid_ff;
    assign RD_DATA_O = arr_rd_data;
    assign RD_ERR_O = rd_err_ff;
    assign FLASH_IRQ_O = |(ris_ff & imr_ff);
endmodule // ofc_top
`default_nettype wire

// ### verification/ofc_top_chk.sv
`default_nettype none
module ofc_top_chk #(
    parameter FLASH_WORDS = 2048
) (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic S_AXI_BVALID_O,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic RD_REQ_I,
    input wire logic [31:0] RD_ADDR_I,
    input wire logic RD_FETCH_I,
    input wire logic RD_VALID_O,
    input wire logic [31:0] RD_DATA_O,
    input wire logic RD_ERR_O
);
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_N_I);
    property p_bvalid_hold;
        S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");
    property p_arready;
        S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O;
    endproperty
    a_arready: assert property (p_arready) else $error("read answer dropped early");
    property p_r_answer;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("register read not answered");
    property p_rd_answer;
        RD_REQ_I |=> RD_VALID_O;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("flash read not answered");
    property p_rd_quiet;
        !RD_REQ_I |=> !RD_VALID_O && !RD_ERR_O;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("flash read answer without request");
    property p_err_data;
        RD_ERR_O |-> RD_VALID_O && RD_DATA_O == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("refused read leaked data");
    property p_fetch_ok;
        RD_REQ_I && RD_FETCH_I && RD_ADDR_I[1:0] == 2'h0 && RD_ADDR_I < FLASH_WORDS * 4 |=> !RD_ERR_O;
    endproperty
    a_fetch_ok: assert property (p_fetch_ok) else $error("instruction fetch refused");
    property p_unaligned;
        RD_REQ_I && RD_ADDR_I[1:0] != 2'h0 |=> RD_ERR_O;
    endproperty
    a_unaligned: assert property (p_unaligned) else $error("unaligned read not refused");
endmodule // ofc_top_chk
`default_nettype wire

// ### verification/ofc_core_model.sv
`default_nettype none
module ofc_core_model (
    input wire logic clk_i,
    output logic req_o,
    output logic [31:0] addr_o,
    output logic fetch_o,
    input wire logic valid_i,
    input wire logic [31:0] data_i,
    input wire logic err_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        req_o <= 1'b0;
        addr_o <= 32'h0;
        fetch_o <= 1'b0;
    end
    // Issues one read; released lines show the inverse of the last value.
    task automatic rd(input logic [31:0] a, input logic f, output logic [31:0] d, output logic e);
        req_o <= 1'b1;
        addr_o <= a;
        fetch_o <= f;
        @(posedge clk_i);
        req_o <= 1'b0;
        addr_o <= ~a;
        fetch_o <= ~f;
        @(negedge clk_i);
        d = valid_i ? data_i : ~data_i;
        e = err_i | ~valid_i;
        @(posedge clk_i);
    endtask
endmodule // ofc_core_model
`default_nettype wire

// ### verification/ofc_tb_top.sv
`default_nettype none
`include "ofc_defines.vh"
module ofc_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] BAD [4] = '{32'h800, 32'h1000, 32'h404, 32'h2000};
    logic clk, rst_n, por_n, awv, wv, bry, arv, rry;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, st, v;
    logic [1:0] lresp;
    wire awrdy, wrdy, bvalid, arrdy, rvalid, rd_valid, rd_err, irq, rd_req, rd_fetch;
    wire [31:0] rdata, rd_data, rd_addr;
    wire [1:0] bresp, rresp;
    int err_count, n_compared;
    ofc_top ofc_top_i (.CLOCK_I(clk), .RST_N_I(rst_n), .POR_N_I(por_n), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF),
        .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rry),
        .RD_REQ_I(rd_req), .RD_ADDR_I(rd_addr), .RD_FETCH_I(rd_fetch), .RD_VALID_O(rd_valid),
        .RD_DATA_O(rd_data), .RD_ERR_O(rd_err), .FLASH_IRQ_O(irq));
    ofc_core_model core_i (.clk_i(clk), .req_o(rd_req), .addr_o(rd_addr), .fetch_o(rd_fetch),
        .valid_i(rd_valid), .data_i(rd_data), .err_i(rd_err));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            ta = pa & (awrdy === 1'b1);
            tw = pw & (wrdy === 1'b1);
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            pa = pa & ~ta;
            pw = pw & ~tw;
        end
        ta = 1'b0;
        while (!ta) begin
            @(negedge clk);
            ta = (bvalid === 1'b1);
            @(posedge clk);
        end
        bry <= 1'b1;
        @(negedge clk);
        lresp = bresp;
        @(posedge clk);
        bry <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic t;
        t = 1'b0;
        araddr <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        while (!t) begin
            @(negedge clk);
            t = (arrdy === 1'b1);
            @(posedge clk);
        end
        arv <= 1'b0;
        t = 1'b0;
        while (!t) begin
            @(negedge clk);
            t = (rvalid === 1'b1);
            d = rdata;
            lresp = rresp;
            @(posedge clk);
        end
        rry <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rd(a, v);
        chk(nm, e, v);
    endtask
    task automatic run(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
        wr(`OFC_REG_ADDR, a);
        wr(`OFC_REG_DATA, d);
        wr(`OFC_REG_CMD, c);
        st = 32'h1;
        while (st[0] !== 1'b0) rd(`OFC_REG_CMD, st);
    endtask
    task automatic frd(input logic [31:0] a, input logic f, input logic [31:0] e, input logic ee);
        logic [31:0] d;
        logic er;
        core_i.rd(a, f, d, er);
        chk("flash_data", e, d);
        chk("flash_err", {31'h0, ee}, {31'h0, er});
    endtask
    task automatic timed(input logic [7:0] u, input logic [31:0] a);
        int n;
        n = 0;
        wr(`OFC_REG_USEC, {24'h0, u});
        wr(`OFC_REG_ICR, 32'h3);
        wr(`OFC_REG_ADDR, a);
        wr(`OFC_REG_CMD, 32'h1);
        while (irq !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk("prog_time", 32'h1, {31'h0, n >= `OFC_PROG_TIME_US * u - 5 && n <= `OFC_PROG_TIME_US * u + 5});
        run(a, 32'hF0, 32'h0);
    endtask
    task automatic tdone(input string s);
        $display("test %0s done", s);
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop;
    end
    initial begin
        err_count = 0;
        n_compared = 0;
        {rst_n, por_n, awv, wv, bry, arv, rry} <= 7'h0;
        {awaddr, araddr, wdata} <= 48'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        rchk("usec_rst", `OFC_REG_USEC, 32'h0A);
        rchk("ris_rst", `OFC_REG_RIS, 32'h0);
        rchk("unmapped", 8'h3C, 32'h0);
        chk("unmapped_resp", {30'h0, `OFC_RESP_SLVERR}, {30'h0, lresp});
        wr(8'h3C, 32'h0);
        chk("unmapped_wr_resp", {30'h0, `OFC_RESP_SLVERR}, {30'h0, lresp});
        tdone("reset");
        wr(`OFC_REG_USEC, 32'h1);
        wr(`OFC_REG_IMR, 32'h3);
        chk("wr_resp", {30'h0, `OFC_RESP_OKAY}, {30'h0, lresp});
        for (int i = 1; i < 5; i++) begin
            run(i * 32'h400, 32'h0, 32'h2);
            chk("erase_fail", 32'h0, {31'h0, st[1]});
            frd(i * 32'h400, 1'b1, `OFC_ONES, 1'b0);
            frd(i * 32'h400 + 32'h3FC, 1'b1, `OFC_ONES, 1'b0);
        end
        rchk("ris_done", `OFC_REG_RIS, 32'h1);
        chk("irq_done", 32'h1, {31'h0, irq});
        tdone("erase");
        run(32'h400, 32'h12345678, 32'h1);
        run(32'h400, 32'h0F0F0F0F, 32'h1);
        frd(32'h400, 1'b0, 32'h12345678 & 32'h0F0F0F0F, 1'b0);
        frd(32'h404, 1'b0, `OFC_ONES, 1'b0);
        timed(8'h1, 32'h408);
        timed(8'h4, 32'h40C);
        tdone("program");
        wr(`OFC_REG_ICR, 32'h3);
        rchk("ris_clr", `OFC_REG_RIS, 32'h0);
        wr(`OFC_REG_IMR, 32'h2);
        run(32'h410, 32'h0, 32'h1);
        rchk("ris_masked", `OFC_REG_RIS, 32'h1);
        rchk("mis_masked", `OFC_REG_MIS, 32'h0);
        chk("irq_masked", 32'h0, {31'h0, irq});
        tdone("mask");
        wr(`OFC_REG_PROT, 32'h24);
        wr(`OFC_REG_ICR, 32'h1);
        run(32'hC00, 32'h0, 32'h1);
        chk("ro_prog_fail", 32'h1, {31'h0, st[1]});
        frd(32'hC00, 1'b0, `OFC_ONES, 1'b0);
        rchk("ris_viol", `OFC_REG_RIS, 32'h2);
        chk("irq_viol", 32'h1, {31'h0, irq});
        for (int i = 0; i < 4; i++) begin
            run(BAD[i], 32'h0, 32'h2);
            chk("erase_refused", 32'h1, {31'h0, st[1]});
        end
        frd(32'h1000, 1'b0, 32'h0, 1'b1);
        frd(32'h1000, 1'b1, `OFC_ONES, 1'b0);
        frd(32'h402, 1'b0, 32'h0, 1'b1);
        tdone("protect");
        wr(`OFC_REG_PROT, 32'h0);
        rchk("prot_tighten", `OFC_REG_PROT, 32'h24);
        run(32'h0, 32'h0, 32'h4);
        rchk("perm", `OFC_REG_PERM, 32'h24);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rchk("prot_rst", `OFC_REG_PROT, 32'h0);
        rchk("perm_rst", `OFC_REG_PERM, 32'h24);
        rchk("usec_rst2", `OFC_REG_USEC, 32'h0A);
        run(32'hC00, 32'h0, 32'h1);
        chk("perm_prog_fail", 32'h1, {31'h0, st[1]});
        frd(32'hC00, 1'b0, `OFC_ONES, 1'b0);
        tdone("commit");
        report_and_stop;
    end
endmodule // ofc_tb_top
bind ofc_top ofc_top_chk #(.FLASH_WORDS(FLASH_WORDS)) ofc_top_chk_i (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
    .S_AXI_RREADY_I(S_AXI_RREADY_I),
    .RD_REQ_I(RD_REQ_I), .RD_ADDR_I(RD_ADDR_I), .RD_FETCH_I(RD_FETCH_I), .RD_VALID_O(RD_VALID_O),
    .RD_DATA_O(RD_DATA_O), .RD_ERR_O(RD_ERR_O));
`default_nettype wire
